// ### pdmc_core.sv
// parity dram module core: decode, strobes, parity and status register
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pdmc_params.svh"
module pdmc_core
  import pdmc_pkg::*;
#(
  parameter int REF_CYCLES = `PDMC_REF_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUS_INIT,
  // configuration options
  input wire logic [8:0] START_ADDR,
  input wire logic HALF_EN,
  input wire logic HALF_USE_ROW1,
  input wire logic TESTER_EN,
  input wire logic REPORT_EN,
  // memory request from bus handshake logic
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [21:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic REQ_DATA_ADDRESS_LINE_16,
  output logic REQ_READY,
  output logic SELECTED,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic PERR_LINE16,
  output logic PERR_LINE17,
  output logic LATCHED_PARITY_FAULT,
  // storage array
  output logic [1:0] ROW_STROBE,
  output logic COL_STROBE,
  output logic [7:0] MEM_ADDR,
  output logic MEM_WE,
  output logic [17:0] MEM_WDATA,
  input wire logic [17:0] MEM_RDATA,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA
);
  pdmc_link_if lnk ();

  pdmc_parity u_par (
    .lnk(lnk.par)
  );

  pdmc_refresh #(
    .REF_CYCLES(REF_CYCLES)
  ) u_ref (
    .clk(CLK),
    .reset_n(RESET_N),
    .lnk(lnk.refr)
  );

  pdmc_state_e state_ff, nxt_state;
  logic [21:0] lat_addr_ff, nxt_lat_addr;
  logic lat_row_ff, nxt_lat_row;
  logic lat_write_ff, nxt_lat_write;
  logic [17:0] wword_ff, nxt_wword;
  logic [15:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic rpt_ff, nxt_rpt;
  logic fault_ff, nxt_fault;
  logic rpt_en_ff, nxt_rpt_en;
  logic force_ff, nxt_force;
  logic ext_ff, nxt_ext;
  logic err_ff, nxt_err;
  logic [6:0] cap_lo_ff, nxt_cap_lo;
  logic [3:0] cap_hi_ff, nxt_cap_hi;
  logic [15:0] reg_rdata_ff, nxt_reg_rdata;
  logic sel;
  logic sel_row;
  logic take_req;
  logic read_fault;
  logic csr_hit;

  // ----------------------------------------------------------------
  // module selection and row decode
  // ----------------------------------------------------------------
  // unit is 4K words; the full module spans 32 units, half spans 16
  function automatic logic [1:0] decode_sel(input logic [21:0] a,
    input logic [8:0] start, input logic half, input logic use1);
    logic [8:0] ofs;
    logic hit;
    logic row;
    ofs = 9'(a[21:13] - start);
    hit = (a[21:13] >= start) &&
      (ofs < (half ? `PDMC_HALF_UNITS : `PDMC_FULL_UNITS));
    row = half ? use1 : ofs[4];
    decode_sel = {row, hit};
  endfunction

  always_comb begin
    {sel_row, sel} = decode_sel(REQ_ADDR, START_ADDR, HALF_EN,
      HALF_USE_ROW1);
  end

  assign REQ_READY = (state_ff == ST_IDLE);
  assign take_req = REQ_READY & REQ_VALID & sel;
  assign SELECTED = sel;

  // ----------------------------------------------------------------
  // memory timing
  // ----------------------------------------------------------------
  // a bus request beats a pending refresh in the same idle cycle; the
  // refresh waits out every four-cycle access taken ahead of it, with no bound on how many
  always_comb begin
    nxt_state = state_ff;
    nxt_lat_addr = lat_addr_ff;
    nxt_lat_row = lat_row_ff;
    nxt_lat_write = lat_write_ff;
    nxt_wword = wword_ff;
    lnk.ref_ack = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (take_req) begin
          nxt_lat_addr = REQ_ADDR;
          nxt_lat_row = sel_row;
          nxt_lat_write = REQ_WRITE;
          nxt_wword = {lnk.wpar, REQ_WDATA};
          nxt_state = ST_ROW;
        end else if (lnk.ref_req) begin
          lnk.ref_ack = 1'b1;
          nxt_state = ST_REF;
        end
      end
      ST_ROW: nxt_state = ST_COL;
      ST_COL: nxt_state = ST_END;
      ST_REF: nxt_state = ST_END;
      ST_END: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
      lat_addr_ff <= 22'h000000;
      lat_row_ff <= 1'b0;
      lat_write_ff <= 1'b0;
      wword_ff <= 18'h00000;
    end else begin
      state_ff <= nxt_state;
      lat_addr_ff <= nxt_lat_addr;
      lat_row_ff <= nxt_lat_row;
      lat_write_ff <= nxt_lat_write;
      wword_ff <= nxt_wword;
    end
  end

  assign lnk.wdata = REQ_WDATA;
  assign lnk.force_bad = force_ff | (TESTER_EN & REQ_DATA_ADDRESS_LINE_16);
  assign lnk.rword = MEM_RDATA;

  // ----------------------------------------------------------------
  // strobes and array address
  // ----------------------------------------------------------------
  // register traffic uses the register port and never enters here, so
  // no row strobe can fire for it
  always_comb begin
    ROW_STROBE = 2'b00;
    COL_STROBE = 1'b0;
    MEM_ADDR = 8'h00;
    case (state_ff)
      ST_ROW, ST_COL: begin
        ROW_STROBE = lat_row_ff ? 2'b10 : 2'b01;
        COL_STROBE = (state_ff == ST_COL);
        MEM_ADDR = (state_ff == ST_ROW) ? lat_addr_ff[16:9] :
          lat_addr_ff[8:1];
      end
      ST_REF: begin
        ROW_STROBE = 2'b11;
        MEM_ADDR = lnk.ref_addr;
      end
      default: ROW_STROBE = 2'b00;
    endcase
  end

  assign MEM_WE = (state_ff == ST_COL) & lat_write_ff;
  assign MEM_WDATA = wword_ff;

  // ----------------------------------------------------------------
  // read data, checking and reporting
  // ----------------------------------------------------------------
  assign read_fault = (state_ff == ST_COL) & ~lat_write_ff &
    lnk.par_err;

  always_comb begin
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_rpt = 1'b0;
    nxt_fault = fault_ff;
    if ((state_ff == ST_COL) && !lat_write_ff) begin
      nxt_rd_data = MEM_RDATA[15:0];
      nxt_rd_valid = 1'b1;
      nxt_fault = lnk.par_err;
      nxt_rpt = lnk.par_err & REPORT_EN & rpt_en_ff;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      rpt_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      rpt_ff <= nxt_rpt;
      fault_ff <= nxt_fault;
    end
  end

  assign RD_DATA = rd_data_ff;
  assign RD_VALID = rd_valid_ff;
  assign PERR_LINE16 = rpt_ff & err_ff;
  assign PERR_LINE17 = rpt_ff & err_ff;
  assign LATCHED_PARITY_FAULT = fault_ff;

  // ----------------------------------------------------------------
  // control and status register
  // ----------------------------------------------------------------
  assign csr_hit = (REG_ADDR == `PDMC_CSR_OFS);

  always_comb begin
    nxt_rpt_en = rpt_en_ff;
    nxt_force = force_ff;
    nxt_ext = ext_ff;
    nxt_err = err_ff;
    nxt_cap_lo = cap_lo_ff;
    nxt_cap_hi = cap_hi_ff;
    nxt_reg_rdata = 16'h0000;
    if (REG_WR && csr_hit) begin
      nxt_rpt_en = REG_WDATA[`PDMC_BIT_RPT_EN];
      nxt_force = REG_WDATA[`PDMC_BIT_FORCE];
      nxt_ext = REG_WDATA[`PDMC_BIT_EXT];
      nxt_err = REG_WDATA[`PDMC_BIT_ERR];
      nxt_cap_lo = REG_WDATA[11:5];
    end
    // a fault in the same cycle as a write wins over the written value
    if (read_fault) begin
      nxt_err = 1'b1;
      nxt_cap_lo = lat_addr_ff[17:11];
      nxt_cap_hi = lat_addr_ff[21:18];
    end
    if (BUS_INIT) begin
      nxt_rpt_en = 1'b0;
      nxt_force = 1'b0;
      nxt_ext = 1'b0;
      nxt_err = 1'b0;
    end
    if (REG_RD && csr_hit) begin
      nxt_reg_rdata = `PDMC_CSR_ONES;
      nxt_reg_rdata[`PDMC_BIT_RPT_EN] = rpt_en_ff;
      nxt_reg_rdata[`PDMC_BIT_FORCE] = force_ff;
      nxt_reg_rdata[11:5] = ext_ff ? {cap_lo_ff[6:4], cap_hi_ff} :
        cap_lo_ff;
      nxt_reg_rdata[`PDMC_BIT_EXT] = ext_ff;
      nxt_reg_rdata[`PDMC_BIT_ERR] = err_ff;
    end
  end

  // captured address is data, not control: bus init leaves it alone
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rpt_en_ff <= 1'b0;
      force_ff <= 1'b0;
      ext_ff <= 1'b0;
      err_ff <= 1'b0;
      cap_lo_ff <= 7'h00;
      cap_hi_ff <= 4'h0;
      reg_rdata_ff <= `PDMC_CSR_RESET;
    end else begin
      rpt_en_ff <= nxt_rpt_en;
      force_ff <= nxt_force;
      ext_ff <= nxt_ext;
      err_ff <= nxt_err;
      cap_lo_ff <= nxt_cap_lo;
      cap_hi_ff <= nxt_cap_hi;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  assign REG_RDATA = reg_rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sel_range: assert property (@(posedge CLK) disable iff (!RESET_N)
    take_req |-> (REQ_ADDR[21:13] >= START_ADDR) &&
      (9'(REQ_ADDR[21:13] - START_ADDR) <
        (HALF_EN ? 9'h010 : 9'h020)))
    else $error("selected outside configured range");

  a_one_row: assert property (@(posedge CLK) disable iff (!RESET_N)
    COL_STROBE |-> $onehot(ROW_STROBE))
    else $error("column strobe without exactly one row strobe");

  a_ref_all_rows: assert property (@(posedge CLK) disable iff (!RESET_N)
    lnk.ref_ack |=> (ROW_STROBE == 2'b11) && !COL_STROBE
      && (MEM_ADDR == $past(lnk.ref_addr)))
    else $error("refresh cycle strobes wrong");

  a_half_row: assert property (@(posedge CLK) disable iff (!RESET_N)
    take_req && HALF_EN |=> ROW_STROBE[HALF_USE_ROW1 ? 1 : 0]
      && !ROW_STROBE[HALF_USE_ROW1 ? 0 : 1])
    else $error("half option used wrong row");

  a_upper_row: assert property (@(posedge CLK) disable iff (!RESET_N)
    take_req && !HALF_EN && (9'(REQ_ADDR[21:13] - START_ADDR) >= 9'h010)
      |=> ROW_STROBE == 2'b10)
    else $error("second half not on row 1");

  a_addr_stable: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state_ff == ST_ROW) |=> $stable(lat_addr_ff) && COL_STROBE
      ##1 $stable(lat_addr_ff))
    else $error("latched address moved during cycle");

  a_wpar_gen: assert property (@(posedge CLK) disable iff (!RESET_N)
    take_req && !lnk.force_bad |=> (^{wword_ff[16], wword_ff[7:0]} == 1'b1)
      && (^{wword_ff[17], wword_ff[15:8]} == 1'b0))
    else $error("generated parity wrong");

  a_err_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
    read_fault && !BUS_INIT |=> err_ff && fault_ff
      && cap_lo_ff == $past(lat_addr_ff[17:11]))
    else $error("fault not captured");

  a_no_wr_check: assert property (@(posedge CLK) disable iff (!RESET_N)
    MEM_WE |=> !rd_valid_ff && !rpt_ff)
    else $error("write cycle checked parity");

  a_report_lines: assert property (@(posedge CLK) disable iff (!RESET_N)
    PERR_LINE16 |-> PERR_LINE17 && err_ff && rpt_en_ff && RD_VALID)
    else $error("report lines without enable");
endmodule
`default_nettype wire

// ### pdmc_params.svh
// constants for the parity dram module core
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH
`define PDMC_CSR_OFS 4'h0
`define PDMC_BIT_RPT_EN 0
`define PDMC_BIT_FORCE 2
`define PDMC_BIT_CAP_LO 5
`define PDMC_BIT_EXT 14
`define PDMC_BIT_ERR 15
`define PDMC_CSR_ONES 16'h001A
`define PDMC_CSR_RESET 16'h0000
`define PDMC_CLK_PERIOD_NS 10
`define PDMC_REF_PERIOD_NS 14500
`define PDMC_REF_CYCLES (`PDMC_REF_PERIOD_NS / `PDMC_CLK_PERIOD_NS)
`define PDMC_REF_MIN_COUNT 128
`define PDMC_REF_WINDOW_NS 2000000
`define PDMC_HALF_UNITS 9'h010
`define PDMC_FULL_UNITS 9'h020
`endif

// ### pdmc_pkg.sv
// types shared by the parity dram module core
package pdmc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_COL,
    ST_REF,
    ST_END
  } pdmc_state_e;
  typedef logic [17:0] pdmc_word_t;
endpackage

// ### pdmc_link_if.sv
// signals between the core and its parity and refresh helpers
`timescale 1ns/1ns
`default_nettype none
interface pdmc_link_if;
  logic [15:0] wdata;
  logic force_bad;
  logic [1:0] wpar;
  logic [17:0] rword;
  logic par_err;
  logic ref_req;
  logic ref_ack;
  logic [7:0] ref_addr;
  modport core (output wdata, force_bad, rword, ref_ack,
    input wpar, par_err, ref_req, ref_addr);
  modport par (input wdata, force_bad, rword, output wpar, par_err);
  modport refr (input ref_ack, output ref_req, ref_addr);
endinterface
`default_nettype wire

// ### pdmc_parity.sv
// byte parity generator and checker
`timescale 1ns/1ns
`default_nettype none
module pdmc_parity
  import pdmc_pkg::*;
(
  // link to the core
  pdmc_link_if.par lnk
);
  logic [1:0] gen;

  // ----------------------------------------------------------------
  // generation: low byte odd, high byte even
  // ----------------------------------------------------------------
  always_comb begin
    gen[0] = ~(^lnk.wdata[7:0]);
    gen[1] = ^lnk.wdata[15:8];
    lnk.wpar = lnk.force_bad ? ~gen : gen;
  end

  // ----------------------------------------------------------------
  // checking: byte 0 group even, byte 1 group odd
  // ----------------------------------------------------------------
  always_comb begin
    lnk.par_err = (^{lnk.rword[16], lnk.rword[7:0]}) |
      ~(^{lnk.rword[17], lnk.rword[15:8]});
  end
endmodule
`default_nettype wire

// ### pdmc_refresh.sv
// refresh request timer and refresh address counter
`timescale 1ns/1ns
`default_nettype none
`include "pdmc_params.svh"
module pdmc_refresh
  import pdmc_pkg::*;
#(
  parameter int REF_CYCLES = `PDMC_REF_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link to the core
  pdmc_link_if.refr lnk
);
  logic [12:0] cnt_ff, nxt_cnt;
  logic pend_ff, nxt_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic wrap;

  // ----------------------------------------------------------------
  // request every period; a wrap in the ack cycle is kept
  // ----------------------------------------------------------------
  always_comb begin
    wrap = (cnt_ff == 13'(REF_CYCLES - 1));
    nxt_cnt = wrap ? 13'h0000 : 13'(cnt_ff + 13'h0001);
    nxt_pend = wrap | (pend_ff & ~lnk.ref_ack);
    nxt_addr = wrap ? 8'(addr_ff + 8'h01) : addr_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 13'h0000;
      pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      pend_ff <= nxt_pend;
      addr_ff <= nxt_addr;
    end
  end

  assign lnk.ref_req = pend_ff;
  assign lnk.ref_addr = addr_ff;

  a_ref_raised: assert property (@(posedge clk) disable iff (!reset_n)
    wrap |=> pend_ff)
    else $error("refresh request not raised at period end");
endmodule
`default_nettype wire

// ### pdmc_array_model.sv
// storage array model standing behind the core's strobes
`timescale 1ns/1ns
`default_nettype none
module pdmc_array_model (
  // clock
  input wire logic clk,
  // strobes, address and write word from the core
  input wire logic [1:0] row_strobe,
  input wire logic col_strobe,
  input wire logic [7:0] mem_addr,
  input wire logic mem_we,
  input wire logic [17:0] mem_wdata,
  // stored word back to the core
  output logic [17:0] mem_rdata
);
  // two rows of 64K cells of 18 bits, kept sparse
  logic [17:0] mem [int];
  logic [7:0] row_ff = 8'h00;
  logic [7:0] ref_ff = 8'h00;
  logic [17:0] last_ff = 18'h00000;
  logic [17:0] last_wr = 18'h00000;
  logic [1:0] last_row = 2'h0;
  int ref_count = 0;
  int bad = 0;
  int key;
  assign key = {15'h0000, row_strobe[1], row_ff, mem_addr};
  // idle or unwritten reads give the inverse of the last word,
  // so a stale value is never taken for read data
  assign mem_rdata = (col_strobe && mem.exists(key)) ? mem[key] : ~last_ff;
  always @(posedge clk) begin
    last_ff <= mem_rdata;
    if (row_strobe == 2'b11) begin
      ref_count <= ref_count + 1;
      ref_ff <= mem_addr;
      if (col_strobe || (ref_count > 0 && mem_addr != ref_ff + 8'h01)) begin
        bad <= bad + 1;
      end
    end else if (col_strobe) begin
      last_row <= row_strobe;
      if (row_strobe != 2'b01 && row_strobe != 2'b10) begin
        bad <= bad + 1;
      end
      if (mem_we) begin
        mem[key] = mem_wdata;
        last_wr <= mem_wdata;
      end
    end else if (row_strobe != 2'b00) begin
      row_ff <= mem_addr;
    end
  end
endmodule
`default_nettype wire

// ### tb_parity_dram_module_core.sv
// self-checking testbench for the parity dram module core
`timescale 1ns/1ns
`default_nettype none
`include "pdmc_params.svh"
module tb_parity_dram_module_core;
  import pdmc_pkg::*;
  // short refresh interval so the run sees many refreshes
  localparam int REF_N = 20;
  typedef struct packed {
    logic [8:0] st;
    logic [21:0] a;
    logic h;
    logic u;
    logic s;
    logic [1:0] r;
  } pdmc_dec_s;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic BUS_INIT = 1'b0;
  logic [8:0] START_ADDR = 9'h000;
  logic HALF_EN = 1'b0;
  logic HALF_USE_ROW1 = 1'b0;
  logic TESTER_EN = 1'b0;
  logic REPORT_EN = 1'b0;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [21:0] REQ_ADDR = 22'h000000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic REQ_DATA_ADDRESS_LINE_16 = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic REQ_READY, SELECTED, RD_VALID, PERR_LINE16, PERR_LINE17;
  logic LATCHED_PARITY_FAULT, COL_STROBE, MEM_WE;
  logic [15:0] RD_DATA, REG_RDATA;
  logic [1:0] ROW_STROBE;
  logic [7:0] MEM_ADDR;
  logic [17:0] MEM_WDATA, MEM_RDATA;
  int num_errors = 0;
  int samples_checked = 0;
  int i;
  logic got_rd, p16, p17, flt;
  logic [15:0] rd, v;
  logic [15:0] reg_w [3] = '{16'h8005, 16'h3FE0, 16'h0000};
  logic [15:0] reg_e [3] = '{16'h801F, 16'h0FFA, 16'h001A};
  logic [15:0] gen_d [5] = '{16'h0000, 16'h00FF, 16'h0100, 16'hA5C3,
    16'h8001};
  logic [17:0] chk_w [5] = '{18'h10000, 18'h20000, 18'h00100, 18'h00000,
    18'h30001};
  // fault per chk_w row: byte 0 group odd or byte 1 group even
  logic [4:0] chk_e = 5'b01001;
  pdmc_dec_s dec [10] = '{
    '{9'h000, 22'h000000, 1'b0, 1'b0, 1'b1, 2'b01},
    '{9'h000, 22'h01FFFE, 1'b0, 1'b0, 1'b1, 2'b01},
    '{9'h000, 22'h020000, 1'b0, 1'b0, 1'b1, 2'b10},
    '{9'h000, 22'h03FFFE, 1'b0, 1'b0, 1'b1, 2'b10},
    '{9'h000, 22'h040000, 1'b0, 1'b0, 1'b0, 2'b00},
    '{9'h004, 22'h006000, 1'b0, 1'b0, 1'b0, 2'b00},
    '{9'h004, 22'h008000, 1'b0, 1'b0, 1'b1, 2'b01},
    '{9'h000, 22'h000000, 1'b1, 1'b1, 1'b1, 2'b10},
    '{9'h000, 22'h01FFFE, 1'b1, 1'b0, 1'b1, 2'b01},
    '{9'h000, 22'h020000, 1'b1, 1'b0, 1'b0, 2'b00}};

  pdmc_core #(.REF_CYCLES(REF_N)) DUT (.CLK, .RESET_N, .BUS_INIT,
    .START_ADDR, .HALF_EN, .HALF_USE_ROW1, .TESTER_EN, .REPORT_EN,
    .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .REQ_WDATA, .REQ_DATA_ADDRESS_LINE_16,
    .REQ_READY, .SELECTED, .RD_DATA, .RD_VALID, .PERR_LINE16,
    .PERR_LINE17, .LATCHED_PARITY_FAULT, .ROW_STROBE, .COL_STROBE,
    .MEM_ADDR, .MEM_WE, .MEM_WDATA, .MEM_RDATA, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA);
  pdmc_array_model M (.clk(CLK), .row_strobe(ROW_STROBE),
    .col_strobe(COL_STROBE), .mem_addr(MEM_ADDR), .mem_we(MEM_WE),
    .mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA));

  always #5 CLK = ~CLK;

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [17:0] g, input logic [17:0] x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // odd total on the low group, even total on the high group
  function automatic logic [17:0] gen(input logic [15:0] d,
                                      input logic bad);
    gen = {(^d[15:8]) ^ bad, (~^d[7:0]) ^ bad, d};
  endfunction

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    d = REG_RDATA;
    @(posedge CLK);
  endtask

  // request held until an edge where it is taken
  task automatic mem_acc(input logic w, input logic [21:0] a,
                         input logic [15:0] d);
    int k;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    k = 0;
    do begin
      @(negedge CLK);
      k++;
    end while (!(REQ_READY === 1'b1 && SELECTED === 1'b1) && k < 40);
    check(k < 40, 1'b1);
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    got_rd = 1'b0;
    for (k = 0; k < 8 && !got_rd; k++) begin
      @(negedge CLK);
      if (RD_VALID === 1'b1) begin
        got_rd = 1'b1;
        rd = RD_DATA;
        p16 = PERR_LINE16;
        p17 = PERR_LINE17;
      end
    end
    @(negedge CLK);
    flt = LATCHED_PARITY_FAULT;
    @(posedge CLK);
  endtask

  initial begin
    #300000;
    num_errors++;
    end_sim();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    reg_rd(4'h0, v);
    check(v, `PDMC_CSR_ONES);
    reg_wr(4'h5, 16'hFFFF);
    reg_rd(4'h5, v);
    check(v, 16'h0000);
    for (i = 0; i < 3; i++) begin
      reg_wr(4'h0, reg_w[i]);
      reg_rd(4'h0, v);
      check(v, reg_e[i]);
    end
    for (i = 0; i < 10; i++) begin
      @(posedge CLK);
      START_ADDR <= dec[i].st;
      HALF_EN <= dec[i].h;
      HALF_USE_ROW1 <= dec[i].u;
      REQ_ADDR <= dec[i].a;
      @(negedge CLK);
      check(SELECTED, dec[i].s);
      if (dec[i].s) begin
        mem_acc(1'b1, dec[i].a, 16'h5A5A);
        check(M.last_row, dec[i].r);
      end
    end
    @(posedge CLK);
    START_ADDR <= 9'h000;
    HALF_EN <= 1'b0;
    for (i = 0; i < 5; i++) begin
      mem_acc(1'b1, 22'h000200 + 22'(i * 2), gen_d[i]);
      check(M.last_wr, gen(gen_d[i], 1'b0));
      check(got_rd, 1'b0);
      mem_acc(1'b0, 22'h000200 + 22'(i * 2), 16'h0000);
      check({flt, got_rd, rd}, {2'b11, gen_d[i]});
    end
    for (i = 0; i < 5; i++) begin
      M.mem[128] = chk_w[i];
      mem_acc(1'b0, 22'h000100, 16'h0000);
      check({flt, rd}, {chk_e[i], chk_w[i][15:0]});
    end
    mem_acc(1'b1, 22'h000100, 16'h0000);
    reg_rd(4'h0, v);
    check(LATCHED_PARITY_FAULT, 1'b0);
    reg_wr(4'h0, 16'h0004);
    mem_acc(1'b1, 22'h000300, 16'h1234);
    check(M.last_wr, gen(16'h1234, 1'b1));
    mem_acc(1'b0, 22'h000300, 16'h0000);
    check({flt, rd}, {1'b0, 16'h1234});
    reg_wr(4'h0, 16'h0000);
    for (i = 0; i < 2; i++) begin
      TESTER_EN <= i[0];
      REQ_DATA_ADDRESS_LINE_16 <= 1'b1;
      mem_acc(1'b1, 22'h000300, 16'h1234);
      check(M.last_wr, gen(16'h1234, i[0]));
    end
    REQ_DATA_ADDRESS_LINE_16 <= 1'b0;
    START_ADDR <= 9'h1F0;
    REPORT_EN <= 1'b1;
    reg_wr(4'h0, 16'h0001);
    M.mem[3072] = 18'h00000;
    mem_acc(1'b0, 22'h3E1800, 16'h0000);
    check({p16, p17, flt}, 3'b111);
    reg_rd(4'h0, v);
    check(v, 16'h887B);
    reg_wr(4'h0, v | 16'h4000);
    reg_rd(4'h0, v);
    check(v, 16'hC9FB);
    BUS_INIT <= 1'b1;
    @(posedge CLK);
    BUS_INIT <= 1'b0;
    reg_rd(4'h0, v);
    check(v, 16'h087A);
    for (i = 0; i < 2; i++) begin
      REPORT_EN <= i[0];
      reg_wr(4'h0, {15'h0000, ~i[0]});
      mem_acc(1'b0, 22'h3E1800, 16'h0000);
      check({p16, p17, flt}, 3'b001);
    end
    i = M.ref_count;
    repeat (10 * REF_N) @(posedge CLK);
    check(M.ref_count - i >= 9, 1'b1);
    check(M.bad, 0);
    end_sim();
  end
endmodule
`default_nettype wire
